// >>> logic/gain_link_pkg.sv
// shared constants for the serial gain level link
package gain_link_pkg;
  // byte format
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned ADDR_FLAG  = 7;          // msb set marks an address byte
  localparam int unsigned MASTER_W   = 7;
  localparam int unsigned CHAN_W     = 5;
  localparam int unsigned NUM_CHAN   = 6;
  // address byte decode table
  localparam logic [7:0] MASTER_ADDR  = 8'h80;
  localparam logic [7:0] CHAN_ADDR_LO = 8'h81;     // channel 1
  localparam logic [7:0] CHAN_ADDR_HI = 8'h86;     // channel 6
  localparam logic [7:0] SPARE_ADDR   = 8'hFF;     // address byte that no target answers to
  // target codes, used by the receiver and by the host command register
  localparam logic [2:0] TGT_NONE   = 3'h0;
  localparam logic [2:0] TGT_MASTER = 3'h7;
  // power-on values: master fully attenuated, channels at least gain
  localparam logic [MASTER_W-1:0] MASTER_MUTE = 7'h00;
  localparam logic [CHAN_W-1:0]   CHAN_RESET  = 5'h1F;
  // host register map
  localparam int unsigned  REG_AW    = 8;
  localparam logic [7:0]   REG_CMD   = 8'h00;
  localparam logic [7:0]   REG_STAT  = 8'h04;
  localparam int unsigned  CMD_VAL_LO = 0;
  localparam int unsigned  CMD_TGT_LO = 8;
  // link timing
  localparam int unsigned SYS_CLK_HZ = 100_000_000;
  localparam int unsigned SCLK_MAX_HZ = 1_000_000;
  localparam int unsigned HALF_CYC = (SYS_CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
  localparam int unsigned CNT_W = 6;
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYC - 1);
  localparam logic [3:0] LAST_BIT = 4'h7;
endpackage : gain_link_pkg

// >>> logic/gain_link_if.sv
// four-wire serial link between host and level receiver
`timescale 1ns/1ps
`default_nettype none
interface gain_link_if;
  logic sclk;
  logic sdata;
  logic select_n;
  logic latch_strobe_n;
  modport dev  (input sclk, input sdata, input select_n, input latch_strobe_n);
  modport host (output sclk, output sdata, output select_n, output latch_strobe_n);
endinterface : gain_link_if
`default_nettype wire

// >>> logic/msb_shift_out.sv
// byte serialiser that makes the link clock from sys_clk by a divider
`timescale 1ns/1ps
`default_nettype none
module msb_shift_out (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // byte request
  input  wire logic       start,
  input  wire logic [7:0] byte_in,
  output logic            done,
  // serial pins
  output logic            sclk,
  output logic            sdata
);
  logic [gain_link_pkg::CNT_W-1:0] cnt;
  logic [3:0]                      bits;
  logic [7:0]                      sh;
  logic                            active;

  ////////////////////////////////////////////////////////////////////////////
  // data changes while sclk is high, a half period before the falling edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt    <= '0;
      bits   <= 4'h0;
      sh     <= 8'h00;
      active <= 1'b0;
      sclk   <= 1'b1;
      sdata  <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        sh     <= byte_in;
        sdata  <= byte_in[7];
        bits   <= 4'h0;
        cnt    <= '0;
        active <= 1'b1;
        sclk   <= 1'b1;
      end else if (active) begin
        if (cnt == gain_link_pkg::HALF_LAST) begin
          cnt <= '0;
          if (sclk) begin
            sclk <= 1'b0;                        // receiver samples here
          end else begin
            sclk <= 1'b1;
            if (bits == gain_link_pkg::LAST_BIT) begin
              active <= 1'b0;
              done   <= 1'b1;
            end else begin
              bits  <= bits + 4'h1;
              sh    <= {sh[6:0], 1'b0};
              sdata <= sh[6];
            end
          end
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  end
endmodule : msb_shift_out
`default_nettype wire

// >>> logic/gain_level_receiver.sv
// receiver end: shift register on the link clock, holding registers on the load strobe
// Operation
// - each update is address byte then data
// - byte with msb one is an address
// - byte with msb zero carries level data
// - master takes seven low data bits
// - channel takes five low data bits
// - master code 7F means no attenuation
// - channel code 00h is maximum gain
// - channel steps are one dB each
// - shifting only while select is low
// - transfer only on load strobe rising edge
// - msb first, sampled on falling clock
// - host drops select and strobe, raises later
// - host keeps serial clock at most 1 MHz
// - host may tie select and strobe
// - levels hold while select is high
// - master muted from power-up
`timescale 1ns/1ps
`default_nettype none
module gain_level_receiver (
  // link side
  gain_link_if.dev link,
  input  wire logic rst_n,
  // level outputs to the gain converters
  output logic [gain_link_pkg::MASTER_W-1:0]                        master_level,
  output logic [gain_link_pkg::NUM_CHAN*gain_link_pkg::CHAN_W-1:0]  chan_level,
  output logic                                                      master_mute
);
  logic [7:0]                       shift;
  logic [2:0]                       target;
  logic [2:0]                       next_target;
  logic [gain_link_pkg::CHAN_W-1:0] chan_reg [gain_link_pkg::NUM_CHAN];

  ////////////////////////////////////////////////////////////////////////////
  // shift register runs on the falling link clock, gated by select
  always_ff @(negedge link.sclk or negedge rst_n) begin
    if (!rst_n) begin
      shift <= 8'h00;
    end else if (!link.select_n) begin
      shift <= {shift[6:0], link.sdata};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address decode; the shifter is quiet when the strobe rises, so no sync
  always_comb begin
    next_target = gain_link_pkg::TGT_NONE;
    if (shift == gain_link_pkg::MASTER_ADDR) begin
      next_target = gain_link_pkg::TGT_MASTER;
    end else if (shift >= gain_link_pkg::CHAN_ADDR_LO && shift <= gain_link_pkg::CHAN_ADDR_HI) begin
      next_target = 3'(shift - gain_link_pkg::CHAN_ADDR_LO) + 3'h1;
    end
  end

  // target is consumed by one data byte, so each update is a pair
  always_ff @(posedge link.latch_strobe_n or negedge rst_n) begin
    if (!rst_n) begin
      target <= gain_link_pkg::TGT_NONE;
    end else if (shift[gain_link_pkg::ADDR_FLAG]) begin
      target <= next_target;
    end else begin
      target <= gain_link_pkg::TGT_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // master holding register; code is attenuation inverted, 7F is 0 dB
  always_ff @(posedge link.latch_strobe_n or negedge rst_n) begin
    if (!rst_n) begin
      master_level <= gain_link_pkg::MASTER_MUTE;
      master_mute  <= 1'b1;
    end else if (!shift[gain_link_pkg::ADDR_FLAG] && target == gain_link_pkg::TGT_MASTER) begin
      master_level <= shift[gain_link_pkg::MASTER_W-1:0];
      master_mute  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel holding registers; code 00h is +31 dB, 1Fh is 0 dB, 1 dB a step
  // one array element per process, so no two processes share a variable
  for (genvar i = 0; i < gain_link_pkg::NUM_CHAN; i++) begin : g_chan
    always_ff @(posedge link.latch_strobe_n or negedge rst_n) begin
      if (!rst_n) begin
        chan_reg[i] <= gain_link_pkg::CHAN_RESET;
      end else if (!shift[gain_link_pkg::ADDR_FLAG] && target == 3'(i + 1)) begin
        chan_reg[i] <= shift[gain_link_pkg::CHAN_W-1:0];
      end
    end
    // flop outputs packed onto the port, channel 1 in the low bits
    assign chan_level[i*gain_link_pkg::CHAN_W +: gain_link_pkg::CHAN_W] = chan_reg[i];
  end
endmodule : gain_level_receiver
`default_nettype wire

// >>> logic/gain_level_host.sv
// host end: command register, sends address and data bytes over the link
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module gain_level_host (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // link side
  gain_link_if.host link
);
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FRAME = 2'b01,
    ST_SHIFT = 2'b10,
    ST_LATCH = 2'b11
  } host_state_e;

  host_state_e                     state;
  logic [gain_link_pkg::CNT_W-1:0] hold;
  logic [2:0]                      cmd_tgt;
  logic [6:0]                      cmd_val;
  logic                            second;
  logic                            strobe_n;
  logic                            start;
  logic                            done;
  logic [7:0]                      tx_byte;
  logic                            busy;

  assign busy = (state != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // command capture; writes while busy are dropped
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_tgt <= gain_link_pkg::TGT_NONE;
      cmd_val <= 7'h00;
    end else if (reg_wr && reg_addr == gain_link_pkg::REG_CMD && !busy) begin
      cmd_tgt <= reg_wdata[gain_link_pkg::CMD_TGT_LO +: 3];
      cmd_val <= reg_wdata[gain_link_pkg::CMD_VAL_LO +: 7];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd && reg_addr == gain_link_pkg::REG_CMD) begin
      reg_rdata <= {21'h0, cmd_tgt, 1'b0, cmd_val};
    end else if (reg_rd && reg_addr == gain_link_pkg::REG_STAT) begin
      reg_rdata <= {31'h0, busy};
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte content: address byte first, then the data byte
  // target code 0 must not fold onto the master address, so it gets a spare one
  always_comb begin
    if (!second) begin
      if (cmd_tgt == gain_link_pkg::TGT_MASTER) begin
        tx_byte = gain_link_pkg::MASTER_ADDR;
      end else if (cmd_tgt == gain_link_pkg::TGT_NONE) begin
        tx_byte = gain_link_pkg::SPARE_ADDR;
      end else begin
        tx_byte = gain_link_pkg::CHAN_ADDR_LO + 8'(cmd_tgt) - 8'h01;
      end
    end else if (cmd_tgt == gain_link_pkg::TGT_MASTER) begin
      tx_byte = {1'b0, cmd_val};
    end else begin
      tx_byte = {3'b000, cmd_val[gain_link_pkg::CHAN_W-1:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one frame per byte; select and strobe move together as one line
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= ST_IDLE;
      hold     <= '0;
      second   <= 1'b0;
      strobe_n <= 1'b1;
      start    <= 1'b0;
    end else begin
      start <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (reg_wr && reg_addr == gain_link_pkg::REG_CMD) begin
            state    <= ST_FRAME;
            second   <= 1'b0;
            hold     <= '0;
            strobe_n <= 1'b0;
          end
        end
        ST_FRAME: begin
          if (hold == gain_link_pkg::HALF_LAST) begin
            state <= ST_SHIFT;
            start <= 1'b1;
          end else begin
            hold <= hold + 1'b1;
          end
        end
        ST_SHIFT: begin
          if (done) begin
            state    <= ST_LATCH;
            hold     <= '0;
            strobe_n <= 1'b1;
          end
        end
        ST_LATCH: begin
          if (hold != gain_link_pkg::HALF_LAST) begin
            hold <= hold + 1'b1;
          end else if (!second) begin
            state    <= ST_FRAME;
            second   <= 1'b1;
            hold     <= '0;
            strobe_n <= 1'b0;
          end else begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  assign link.select_n       = strobe_n;
  assign link.latch_strobe_n = strobe_n;

  // serialiser with its own clock divider
  msb_shift_out u_shift (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .start   (start),
    .byte_in (tx_byte),
    .done    (done),
    .sclk    (link.sclk),
    .sdata   (link.sdata)
  );
endmodule : gain_level_host
`default_nettype wire

// >>> dv/gain_link_chk.sv
// protocol and level checker for the gain level link
`timescale 1ns/1ps
`default_nettype none
module gain_link_chk (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // link wires
  input wire logic        sclk,
  input wire logic        sdata,
  input wire logic        select_n,
  input wire logic        latch_strobe_n,
  // receiver levels
  input wire logic [6:0]  master_level,
  input wire logic [29:0] chan_level,
  input wire logic        master_mute
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [6:0] low_cnt;
  logic [3:0] falls;
  logic [7:0] sh;
  logic       want_addr;
  //////////////////////////////////////////////////
  // low phase length, falls per frame, shifted byte, expected byte kind
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt   <= '0;
      falls     <= '0;
      sh        <= '0;
      want_addr <= 1'b1;
    end else begin
      low_cnt <= sclk ? 7'h00 : low_cnt + 7'h01;
      falls   <= select_n ? 4'h0 : falls + 4'($fell(sclk));
      if ($fell(sclk)) sh <= {sh[6:0], sdata};
      if ($rose(select_n)) want_addr <= ~want_addr;
    end
  end
  idle_clock_a: assert property (select_n |-> sclk)
    else $error("link clock moved outside a frame");
  tied_lines_a: assert property (select_n == latch_strobe_n)
    else $error("select and strobe differ");
  low_phase_a: assert property ($rose(sclk) |-> low_cnt == 7'h32)
    else $error("link clock low phase not 50 cycles");
  byte_bits_a: assert property ($rose(select_n) |-> falls == 4'h8)
    else $error("frame without exactly eight clock falls");
  frame_gap_a: assert property ($rose(select_n) |=> select_n [*8])
    else $error("frame gap too short");
  data_stable_a: assert property ($fell(sclk) |-> $stable(sdata))
    else $error("data moved at sampling edge");
  byte_order_a: assert property ($rose(select_n) |-> sh[7] == want_addr)
    else $error("address and data bytes out of order");
  level_hold_a: assert property ($changed({master_level, chan_level}) |-> $rose(latch_strobe_n))
    else $error("level changed without a latch");
  mute_level_a: assert property (master_mute |-> master_level == 7'h00)
    else $error("muted master not fully attenuated");
endmodule : gain_link_chk
`default_nettype wire

// >>> dv/serial_gain_level_loader_test.sv
// self-checking bench: host and receiver joined by the link
`timescale 1ns/1ps
`default_nettype none
module serial_gain_level_loader_test;
  logic        sys_clk = 1'b0;
  logic        rst_n;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [6:0]  master_level;
  logic [29:0] chan_level;
  logic        master_mute;
  logic        rd_q = 1'b0;
  int          num_errors = 0;
  int          checks_done = 0;
  integer      seed = 32'hA61F4282;
  int          k;
  logic [2:0]  cmd_t;
  logic [6:0]  cmd_v;
  logic [31:0] rd_exp[$];
  logic [37:0] lv_exp[$];
  logic [37:0] lv_now;
  //////////////////////////////////////////////////
  // clock, link and both ends
  always #5 sys_clk = ~sys_clk;
  gain_link_if link_if();
  gain_level_host gain_level_host_inst (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link(link_if));
  gain_level_receiver gain_level_receiver_inst (.link(link_if), .rst_n(rst_n),
    .master_level(master_level), .chan_level(chan_level), .master_mute(master_mute));
  gain_link_chk gain_link_chk_inst (.sys_clk(sys_clk), .rst_n(rst_n), .sclk(link_if.sclk),
    .sdata(link_if.sdata), .select_n(link_if.select_n), .latch_strobe_n(link_if.latch_strobe_n),
    .master_level(master_level), .chan_level(chan_level), .master_mute(master_mute));
  task automatic check(input logic [37:0] got, input logic [37:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  // one strobe cycle, released at the next edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= wr;
    reg_rd    <= ~wr;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask : bus
  // send one update, try a second one while busy, then poll until idle
  task automatic cmd(input logic [2:0] t, input logic [6:0] v);
    logic [37:0] nx;
    int          i;
    nx = lv_now;
    if (t == gain_link_pkg::TGT_MASTER) begin
      nx[37]    = 1'b0;
      nx[36:30] = v;
    end else if (t >= 3'h1 && t <= 3'h6) begin
      nx[5*(t-1) +: 5] = v[4:0];
    end
    if (nx !== lv_now) lv_exp.push_back(nx);
    lv_now = nx;
    bus(1'b1, gain_link_pkg::REG_CMD, {21'h0, t, 1'b0, v});
    bus(1'b1, gain_link_pkg::REG_CMD, {21'h0, 3'h7, 1'b0, ~lv_now[36:30]});
    // read data stand in the cycle after the strobe, so look one edge later
    for (i = 0; i < 2000; i++) begin
      bus(1'b0, gain_link_pkg::REG_STAT, 32'h0);
      @(posedge sys_clk);
      if (reg_rdata[0] === 1'b0) break;
    end
    // let the poll's read slot pass before the caller notes its own read
    @(posedge sys_clk);
    if (i == 2000) begin
      num_errors++;
      print_verdict();
    end
  endtask : cmd
  // read results stand only in the cycle after the strobe
  always @(posedge sys_clk) begin
    rd_q <= reg_rd;
    if (rd_q && rd_exp.size() > 0) check(38'(reg_rdata), 38'(rd_exp.pop_front()));
  end
  // any level change must match the oldest pending note
  always @(master_level or chan_level or master_mute) begin
    if (rst_n === 1'b1) begin
      #1;
      check({master_mute, master_level, chan_level},
            lv_exp.size() > 0 ? lv_exp.pop_front() : lv_now);
    end
  end
  // reset, then every target code three times with random values
  initial begin
    rst_n <= 1'b0;                               // an edge from unknown, so async resets fire
    repeat (16) @(posedge sys_clk);
    rst_n  <= 1'b1;
    lv_now = {1'b1, gain_link_pkg::MASTER_MUTE, {6{gain_link_pkg::CHAN_RESET}}};
    check({master_mute, master_level, chan_level}, lv_now);
    rd_exp.push_back(32'h0);
    bus(1'b0, 8'h08, 32'h0);
    for (k = 0; k < 24; k++) begin
      cmd_t = 3'(k % 8);
      cmd_v = 7'($random(seed));
      cmd(cmd_t, cmd_v);
      rd_exp.push_back(32'h0);
      bus(1'b0, gain_link_pkg::REG_STAT, 32'h0);
      // the write tried while busy must not have replaced the command
      rd_exp.push_back({21'h0, cmd_t, 1'b0, cmd_v});
      bus(1'b0, gain_link_pkg::REG_CMD, 32'h0);
    end
    repeat (4) @(posedge sys_clk);
    check(38'(lv_exp.size()), 38'h0);
    print_verdict();
  end
endmodule : serial_gain_level_loader_test
`default_nettype wire
